// [verilog/pdt_pkg.sv]
// Purpose: shared constants and types of the prescaled down timer
// Assumes: apb with 32-bit data, one aligned word per register
// Notes:   register index times four gives the byte address
`default_nettype none

package pdt_pkg;

	// apb address width and register indices (byte address is index times four)
	localparam int unsigned ADDR_W = 12;
	localparam logic [7:0] IDX_PSC  = 8'hd2;
	localparam logic [7:0] IDX_CNT  = 8'hd3;
	localparam logic [7:0] IDX_CTRL = 8'hd4;
	localparam logic [7:0] IDX_STAT = 8'hd5;
	localparam logic [7:0] IDX_MASK = 8'hd6;
	localparam logic [ADDR_W-1:0] ADDR_PSC  = {2'h0, IDX_PSC, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CNT  = {2'h0, IDX_CNT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'h0, IDX_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_STAT = {2'h0, IDX_STAT, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MASK = {2'h0, IDX_MASK, 2'h0};

	// reset values and counter limits
	localparam logic [6:0] PSC_RST   = 7'h7f;
	localparam logic [6:0] PSC_ZERO  = 7'h00;
	localparam logic [7:0] CNT_RST   = 8'hff;
	localparam logic [7:0] CNT_ZERO  = 8'h00;
	localparam logic [7:0] CTRL_RST  = 8'h00;
	localparam logic [31:0] RD_ZERO  = 32'h0000_0000;

	// control/status field positions
	localparam int unsigned CTRL_FLAG  = 7;
	localparam int unsigned CTRL_IE    = 6;
	localparam int unsigned CTRL_DIR   = 5;
	localparam int unsigned CTRL_LVL   = 4;
	localparam int unsigned CTRL_RUN   = 3;
	localparam int unsigned CTRL_SEL_HI = 2;
	localparam int unsigned CTRL_SEL_LO = 0;

	// interrupt status bits
	localparam int unsigned IRQ_W        = 2;
	localparam int unsigned IRQ_UNDERFLOW = 0;
	localparam int unsigned IRQ_PINOUT    = 1;
	localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;

	// internal clock divider ahead of the prescaler
	localparam int unsigned INT_DIV = 12;
	localparam logic [3:0] DIV_LAST = 4'(INT_DIV - 1);
	localparam logic [3:0] DIV_RST  = 4'h0;

	// operating mode decoded from direction and level/gate bits
	typedef enum logic [1:0] {
		MODE_EVENT,
		MODE_GATED,
		MODE_OUTPUT
	} pdt_mode_e;

endpackage

`default_nettype wire

// [verilog/pdt_pin_if.sv]
// Purpose: carries the qualified timer pin towards the counting logic
// Assumes: single clock domain
// Notes:   rise is a one-cycle pulse, high is a level
`timescale 1ns/1ps
`default_nettype none

interface pdt_pin_if;
	logic rise;
	logic high;
	modport src (output rise, output high);
	modport dst (input rise, input high);
endinterface

`default_nettype wire

// [verilog/pdt_pin_sync.sv]
// Purpose: synchronises the timer pin and derives edge and level qualifiers
// Assumes: pin may change at any time relative to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none

module pdt_pin_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// raw pin and qualified result
	input  wire logic pin_raw,
	pdt_pin_if.src    pin
);

	logic meta_q;
	logic sync_q;
	logic prev_q;

	// two-stage synchroniser plus a history stage for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign pin.rise = sync_q & ~prev_q;
	assign pin.high = sync_q;

endmodule

`default_nettype wire

// [verilog/pdt_prescaler.sv]
// Purpose: seven-bit down prescaler with selectable power-of-two tap
// Assumes: src_tick is a one-cycle pulse per prescaler input edge
// Notes:   software write wins over a coincident tick
`timescale 1ns/1ps
`default_nettype none

module pdt_prescaler (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// control
	input  wire logic       run,
	input  wire logic       src_tick,
	input  wire logic [2:0] sel,
	input  wire logic       wr,
	input  wire logic [6:0] wdata,
	// state and counter clock
	output logic      [6:0] value_q,
	output logic      [6:0] tap_mask,
	output logic            cnt_tick
);

	genvar i;
	generate
		for (i = 0; i < 7; i++) begin : g_tap
			assign tap_mask[i] = (sel > 3'(i));
		end
	endgenerate

	// counter clock fires as the selected low bits wrap
	assign cnt_tick = run & src_tick & ~wr & ((value_q & tap_mask) == pdt_pkg::PSC_ZERO);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			value_q <= pdt_pkg::PSC_RST;
		end else if (!run) begin
			value_q <= pdt_pkg::PSC_RST;
		end else if (wr) begin
			value_q <= wdata;
		end else if (src_tick) begin
			if (value_q == pdt_pkg::PSC_ZERO) begin
				value_q <= pdt_pkg::PSC_RST;
			end else begin
				value_q <= value_q - 7'h01;
			end
		end
	end

endmodule

`default_nettype wire

// [verilog/pdt_timer.sv]
// Purpose: prescaled eight-bit down timer with apb registers and timer pin
// Assumes: apb master per amba apb3, pin input asynchronous
// Notes:   no wait state; every apb access takes two cycles
`timescale 1ns/1ps
`default_nettype none

module pdt_timer (
	// clock and reset
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [pdt_pkg::ADDR_W-1:0]  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// timer pin
	input  wire logic                        timer_pin_i,
	output logic                             timer_pin_o,
	output logic                             timer_pin_oe,
	// requests
	output logic                             timer_irq,
	output logic                             irq,
	output logic                             wake
);

	logic [31:0]                 prdata_q;
	logic                        pready_q;
	logic                        pslverr_q;
	logic                        flag_q;
	logic                        flag_prev_q;
	logic                        ie_q;
	logic                        dir_q;
	logic                        lvl_q;
	logic                        run_q;
	logic [2:0]                  tap_sel_q;
	logic [7:0]                  cnt_q;
	logic [3:0]                  div_q;
	logic                        pin_lvl_q;
	logic [pdt_pkg::IRQ_W-1:0]   stat_q;
	logic [pdt_pkg::IRQ_W-1:0]   mask_q;
	logic                        timer_irq_q;
	logic                        irq_q;
	logic                        wake_q;
	logic [6:0]                  psc_val;
	logic [6:0]                  tap_mask;
	logic                        cnt_tick;
	logic                        div_tick;
	logic                        src_tick;
	logic                        underflow;
	logic                        flag_rise;
	logic                        setup;
	logic                        apb_wr;
	logic                        hit;
	logic                        wr_psc;
	logic                        wr_cnt;
	logic                        wr_ctrl;
	logic                        wr_stat;
	logic                        wr_mask;
	logic [7:0]                  ctrl_val;
	logic [31:0]                 rd_mux;
	logic [pdt_pkg::IRQ_W-1:0]   stat_set;
	logic [pdt_pkg::IRQ_W-1:0]   stat_clr;
	pdt_pkg::pdt_mode_e          mode;

	pdt_pin_if pin ();

	// pin qualifiers
	pdt_pin_sync pdt_pin_sync_i (
		.clk     (pclk),
		.rst_n   (presetn),
		.pin_raw (timer_pin_i),
		.pin     (pin)
	);

	// prescaler and tap selection
	pdt_prescaler pdt_prescaler_i (
		.clk      (pclk),
		.rst_n    (presetn),
		.run      (run_q),
		.src_tick (src_tick),
		.sel      (tap_sel_q),
		.wr       (wr_psc),
		.wdata    (pwdata[6:0]),
		.value_q  (psc_val),
		.tap_mask (tap_mask),
		.cnt_tick (cnt_tick)
	);

	// apb decode; writes land on the edge that completes the access phase
	assign setup   = psel & ~penable;
	assign apb_wr  = psel & penable & pready_q & pwrite;
	assign wr_psc  = apb_wr & (paddr == pdt_pkg::ADDR_PSC);
	assign wr_cnt  = apb_wr & (paddr == pdt_pkg::ADDR_CNT);
	assign wr_ctrl = apb_wr & (paddr == pdt_pkg::ADDR_CTRL);
	assign wr_stat = apb_wr & (paddr == pdt_pkg::ADDR_STAT);
	assign wr_mask = apb_wr & (paddr == pdt_pkg::ADDR_MASK);

	assign ctrl_val = {flag_q, ie_q, dir_q, lvl_q, run_q, tap_sel_q};

	// read mux; unmapped addresses read zero and flag an error
	always_comb begin
		hit    = 1'b1;
		rd_mux = pdt_pkg::RD_ZERO;
		case (paddr)
			pdt_pkg::ADDR_PSC:  rd_mux[6:0] = psc_val;
			pdt_pkg::ADDR_CNT:  rd_mux[7:0] = cnt_q;
			pdt_pkg::ADDR_CTRL: rd_mux[7:0] = ctrl_val;
			pdt_pkg::ADDR_STAT: rd_mux[pdt_pkg::IRQ_W-1:0] = stat_q;
			pdt_pkg::ADDR_MASK: rd_mux[pdt_pkg::IRQ_W-1:0] = mask_q;
			default:            hit = 1'b0;
		endcase
	end

	// apb answer registered in the setup cycle, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= pdt_pkg::RD_ZERO;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			prdata_q  <= (setup & ~pwrite) ? rd_mux : pdt_pkg::RD_ZERO;
		end
	end

	// divide the core clock by twelve
	assign div_tick = (div_q == pdt_pkg::DIV_LAST);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_q <= pdt_pkg::DIV_RST;
		end else if (div_tick) begin
			div_q <= pdt_pkg::DIV_RST;
		end else begin
			div_q <= div_q + 4'h1;
		end
	end

	// mode decode from direction and level/gate bits
	always_comb begin
		if (dir_q) begin
			mode = pdt_pkg::MODE_OUTPUT;
		end else if (lvl_q) begin
			mode = pdt_pkg::MODE_GATED;
		end else begin
			mode = pdt_pkg::MODE_EVENT;
		end
	end

	always_comb begin
		case (mode)
			pdt_pkg::MODE_EVENT:  src_tick = pin.rise;
			pdt_pkg::MODE_GATED:  src_tick = div_tick & pin.high;
			pdt_pkg::MODE_OUTPUT: src_tick = div_tick;
			default:              src_tick = 1'b0;
		endcase
	end

	// wrap from zero is the underflow
	assign underflow = cnt_tick & (cnt_q == pdt_pkg::CNT_ZERO) & ~wr_cnt;

	// frozen while stopped, since cnt_tick needs run
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= pdt_pkg::CNT_RST;
		end else if (wr_cnt) begin
			cnt_q <= pwdata[7:0];
		end else if (cnt_tick) begin
			cnt_q <= cnt_q - 8'h01;
		end
	end

	// flag cleared only by software; an underflow beats a clearing write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_q <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_FLAG];
		end else if (underflow) begin
			flag_q <= 1'b1;
		end else if (wr_ctrl) begin
			flag_q <= pwdata[pdt_pkg::CTRL_FLAG];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ie_q  <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_IE];
			dir_q <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_DIR];
			lvl_q <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_LVL];
			run_q <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_RUN];
			tap_sel_q <= pdt_pkg::CTRL_RST[pdt_pkg::CTRL_SEL_HI:pdt_pkg::CTRL_SEL_LO];
		end else if (wr_ctrl) begin
			ie_q  <= pwdata[pdt_pkg::CTRL_IE];
			dir_q <= pwdata[pdt_pkg::CTRL_DIR];
			lvl_q <= pwdata[pdt_pkg::CTRL_LVL];
			run_q <= pwdata[pdt_pkg::CTRL_RUN];
			tap_sel_q <= pwdata[pdt_pkg::CTRL_SEL_HI:pdt_pkg::CTRL_SEL_LO];
		end
	end

	// flag rise also covers a software set of the flag
	assign flag_rise = flag_q & ~flag_prev_q;

	// latch level to pin on flag rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_prev_q <= 1'b0;
			pin_lvl_q   <= 1'b0;
		end else begin
			flag_prev_q <= flag_q;
			if (flag_rise) begin
				pin_lvl_q <= lvl_q;
			end
		end
	end

	// no status event pending; declared ahead of its first use
	localparam logic [pdt_pkg::IRQ_W-1:0] IRQ_NONE = pdt_pkg::IRQ_RST;

	// sticky event bits, write one to clear, a new event wins over the clear
	always_comb begin
		stat_set = IRQ_NONE;
		stat_set[pdt_pkg::IRQ_UNDERFLOW] = underflow;
		stat_set[pdt_pkg::IRQ_PINOUT]    = flag_rise & dir_q;
		stat_clr = wr_stat ? pwdata[pdt_pkg::IRQ_W-1:0] : IRQ_NONE;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= pdt_pkg::IRQ_RST;
			mask_q <= pdt_pkg::IRQ_RST;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
			if (wr_mask) begin
				mask_q <= pwdata[pdt_pkg::IRQ_W-1:0];
			end
		end
	end

	// timer request from flag and enable
	// same request drives wake-up, valid in wait and stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_irq_q <= 1'b0;
			wake_q      <= 1'b0;
			irq_q       <= 1'b0;
		end else begin
			timer_irq_q <= flag_q & ie_q;
			wake_q      <= flag_q & ie_q;
			irq_q       <= |(stat_q & mask_q);
		end
	end

	// outputs straight from flops
	assign prdata       = prdata_q;
	assign pready       = pready_q;
	assign pslverr      = pslverr_q;
	assign timer_pin_oe = dir_q;
	assign timer_pin_o  = pin_lvl_q;
	assign timer_irq    = timer_irq_q;
	assign wake         = wake_q;
	assign irq          = irq_q;

	// checks on the counting, pin, request and register read logic
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_flag_rise;
		!flag_q ##1 flag_q;
	endsequence

	sequence s_pin_update;
		##1 (pin_lvl_q == $past(lvl_q, 1));
	endsequence

	property p_irq_req;
		(flag_q && ie_q) |=> timer_irq_q ##0 wake_q;
	endproperty
	a_irq_req: assert property (p_irq_req) else $error("request missing");

	property p_irq_off;
		!ie_q |=> !timer_irq_q;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("request while disabled");

	property p_psc_read;
		(setup && !pwrite && paddr == pdt_pkg::ADDR_PSC) |=> (prdata_q[7] == 1'b0);
	endproperty
	a_psc_read: assert property (p_psc_read) else $error("prescaler bit7 not zero");

	property p_underflow;
		(cnt_tick && cnt_q == pdt_pkg::CNT_ZERO && !wr_cnt)
			|=> (flag_q && cnt_q == pdt_pkg::CNT_RST && stat_q[pdt_pkg::IRQ_UNDERFLOW]);
	endproperty
	a_underflow: assert property (p_underflow) else $error("underflow not flagged");

	property p_dir;
		wr_ctrl |=> (timer_pin_oe == $past(pwdata[pdt_pkg::CTRL_DIR]));
	endproperty
	a_dir: assert property (p_dir) else $error("pin direction wrong");

	property p_pin_out;
		s_flag_rise |-> s_pin_update;
	endproperty
	a_pin_out: assert property (p_pin_out) else $error("pin level not latched");

	property p_stopped;
		(!run_q && !wr_cnt) |=> ($stable(cnt_q) && psc_val == pdt_pkg::PSC_RST);
	endproperty
	a_stopped: assert property (p_stopped) else $error("stopped timer moved");

	property p_tap;
		(src_tick && run_q && (psc_val & tap_mask) != pdt_pkg::PSC_ZERO && !wr_cnt)
			|=> $stable(cnt_q);
	endproperty
	a_tap: assert property (p_tap) else $error("counter clocked off tap");

	property p_reload;
		(run_q && src_tick && !wr_psc && psc_val == pdt_pkg::PSC_ZERO)
			|=> (psc_val == pdt_pkg::PSC_RST);
	endproperty
	a_reload: assert property (p_reload) else $error("prescaler not reloaded");

	property p_gate;
		(mode == pdt_pkg::MODE_GATED && !pin.high) |-> !src_tick;
	endproperty
	a_gate: assert property (p_gate) else $error("gated count with pin low");

	property p_write_wins;
		(wr_cnt && cnt_tick && !flag_q && cnt_q == pdt_pkg::CNT_ZERO && !wr_ctrl)
			|=> (!flag_q && cnt_q == $past(pwdata[7:0]));
	endproperty
	a_write_wins: assert property (p_write_wins) else $error("write lost to underflow");

	property p_pin_edge;
		(pin.rise && mode == pdt_pkg::MODE_EVENT) |-> src_tick ##1 !pin.rise;
	endproperty
	a_pin_edge: assert property (p_pin_edge) else $error("edge not single cycle");

endmodule

`default_nettype wire

// [verilog/pdt_pkg_unused_guard.sv]
`default_nettype none
`default_nettype wire

// [tb/pdt_pin_model.sv]
// Purpose: stands in for the outside source on the timer pin
// Assumes: its level only matters while the block leaves the pin as input
// Notes:   edges are four cycles apart so the synchroniser never misses one
`timescale 1ns/1ps
`default_nettype none

module pdt_pin_model (
	// clock
	input  wire logic clk,
	// level offered to the pin
	output var logic  pin
);
	// the pin starts low so no stray edge is counted after reset
	initial pin = 1'b0;

	// hold a steady level, changed just after an edge
	task automatic hold(input logic v);
		@(posedge clk);
		pin <= v;
	endtask

	// n pulses, each four cycles high and four low
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin <= 1'b1;
			repeat (4) @(posedge clk);
			pin <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask
endmodule

`default_nettype wire

// [tb/pdt_timer_tb_top.sv]
// Purpose: self-checking bench for the prescaled down timer
// Assumes: apb answers when pready is high, no fixed latency assumed
// Notes:   tap checks allow one count of slack for the prescaler phase
`timescale 1ns/1ps
`default_nettype none

module pdt_timer_tb_top;
	localparam int LIMIT = 30000;
	logic                       pclk;
	logic                       presetn;
	logic                       psel;
	logic                       penable;
	logic                       pwrite;
	logic [pdt_pkg::ADDR_W-1:0] paddr;
	logic [31:0]                pwdata;
	logic [31:0]                prdata;
	logic [31:0]                rdat;
	logic                       pready;
	logic                       pslverr;
	logic                       rerr;
	logic                       model_pin;
	logic                       pin_w;
	logic                       timer_pin_o;
	logic                       timer_pin_oe;
	logic                       timer_irq;
	logic                       irq;
	logic                       wake;
	int                         bad_count = 0;
	int                         checked = 0;
	int                         cycles = 0;

	// pin level: the block wins while it drives, else the outside source
	assign pin_w = timer_pin_oe ? timer_pin_o : model_pin;

	pdt_timer pdt_timer_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_pin_i(pin_w),
		.timer_pin_o(timer_pin_o), .timer_pin_oe(timer_pin_oe),
		.timer_irq(timer_irq), .irq(irq), .wake(wake)
	);

	pdt_pin_model pdt_pin_model_i (.clk(pclk), .pin(model_pin));

	// 50 MHz clock
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end

	// hang guard, sized well above the longest expected run
	always @(posedge pclk) begin
		cycles++;
		if (cycles == LIMIT) begin
			bad_count++;
			end_of_test();
		end
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic chk_rng(input string name, input logic [31:0] lo, input logic [31:0] hi,
		input logic [31:0] got);
		checked++;
		if ((got >= lo && got <= hi) !== 1'b1) begin
			bad_count++;
			$display("[ERR] %s expected %h to %h seen %h", name, lo, hi, got);
		end
	endtask

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [pdt_pkg::ADDR_W-1:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		// no latency assumed; only the hang guard ends a wait that never sees pready
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [pdt_pkg::ADDR_W-1:0] a, input logic [7:0] d);
		apb(1'b1, a, {24'h000000, d});
	endtask

	task automatic rd_chk(input logic [pdt_pkg::ADDR_W-1:0] a, input logic [31:0] exp,
		input string name);
		apb(1'b0, a, 32'h00000000);
		chk(name, exp, rdat);
	endtask

	task automatic t_reset_values();
		rd_chk(pdt_pkg::ADDR_PSC, 32'h7f, "prescaler_count");
		rd_chk(pdt_pkg::ADDR_CNT, 32'hff, "timer_count");
		rd_chk(pdt_pkg::ADDR_CTRL, 32'h00, "timer_control_status");
		rd_chk(pdt_pkg::ADDR_STAT, 32'h00, "irq_status");
		apb(1'b0, 12'h000, 32'h00000000);
		chk("unmapped error", 32'h1, {31'h0, rerr});
		chk("unmapped data", 32'h0, rdat);
		wr(pdt_pkg::ADDR_CNT, 8'ha5);
		rd_chk(pdt_pkg::ADDR_CNT, 32'ha5, "timer_count write");
	endtask

	// event mode with the pin idle: nothing counts, so values are exact
	task automatic t_prescaler_access();
		wr(pdt_pkg::ADDR_CTRL, 8'h08);
		wr(pdt_pkg::ADDR_PSC, 8'hc5);
		rd_chk(pdt_pkg::ADDR_PSC, 32'h45, "prescaler top bit");
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
		rd_chk(pdt_pkg::ADDR_PSC, 32'h7f, "prescaler stopped");
		repeat (100) @(posedge pclk);
		rd_chk(pdt_pkg::ADDR_CNT, 32'ha5, "counter frozen");
	endtask

	task automatic t_event_count();
		wr(pdt_pkg::ADDR_CNT, 8'hff);
		wr(pdt_pkg::ADDR_CTRL, 8'h08);
		pdt_pin_model_i.pulses(5);
		repeat (6) @(posedge pclk);
		rd_chk(pdt_pkg::ADDR_CNT, 32'hfa, "event count");
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
	endtask

	// a counter write landing with the wrapping tick wins and sets no flag
	task automatic t_write_wins();
		wr(pdt_pkg::ADDR_CNT, 8'h00);
		wr(pdt_pkg::ADDR_CTRL, 8'h08);
		// the pin rise reaches the prescaler three edges on, as the write lands
		fork
			pdt_pin_model_i.hold(1'b1);
			begin
				@(posedge pclk);
				wr(pdt_pkg::ADDR_CNT, 8'h42);
			end
		join
		rd_chk(pdt_pkg::ADDR_CNT, 32'h42, "counter write wins");
		rd_chk(pdt_pkg::ADDR_CTRL, 32'h08, "no flag on masked wrap");
		pdt_pin_model_i.hold(1'b0);
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
	endtask

	// divided clock counts only while the pin is high
	task automatic t_gated_count();
		wr(pdt_pkg::ADDR_CNT, 8'h80);
		wr(pdt_pkg::ADDR_CTRL, 8'h18);
		repeat (240) @(posedge pclk);
		rd_chk(pdt_pkg::ADDR_CNT, 32'h80, "gate closed");
		pdt_pin_model_i.hold(1'b1);
		repeat (240) @(posedge pclk);
		pdt_pin_model_i.hold(1'b0);
		repeat (6) @(posedge pclk);
		apb(1'b0, pdt_pkg::ADDR_CNT, 32'h00000000);
		chk_rng("gate open", 32'h6b, 32'h6d, rdat);
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
	endtask

	// every tap over a fixed window of 1536 cycles, i.e. 128 divided ticks
	task automatic t_divide();
		logic [31:0] e;
		for (int n = 0; n < 8; n++) begin
			wr(pdt_pkg::ADDR_CTRL, 8'h00);
			wr(pdt_pkg::ADDR_CNT, 8'hff);
			wr(pdt_pkg::ADDR_CTRL, 8'h28 | 8'(n));
			repeat (1536) @(posedge pclk);
			apb(1'b0, pdt_pkg::ADDR_CNT, 32'h00000000);
			e = 32'hff - (32'h80 >> n);
			chk_rng("tap count", e - 32'h1, e + 32'h1, rdat);
		end
	endtask

	task automatic t_underflow_irq();
		int n;
		n = 0;
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
		wr(pdt_pkg::ADDR_CNT, 8'h01);
		wr(pdt_pkg::ADDR_CTRL, 8'h78);
		while (timer_irq !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk("timer_irq", 32'h1, {31'h0, timer_irq});
		chk("wake", 32'h1, {31'h0, wake});
		chk("timer_pin_oe", 32'h1, {31'h0, timer_pin_oe});
		chk("timer_pin_o", 32'h1, {31'h0, timer_pin_o});
		rd_chk(pdt_pkg::ADDR_CTRL, 32'hf8, "flag after wrap");
		rd_chk(pdt_pkg::ADDR_STAT, 32'h03, "irq_status");
		chk("irq masked", 32'h0, {31'h0, irq});
		wr(pdt_pkg::ADDR_MASK, 8'h01);
		repeat (3) @(posedge pclk);
		chk("irq unmasked", 32'h1, {31'h0, irq});
		wr(pdt_pkg::ADDR_STAT, 8'h03);
		repeat (3) @(posedge pclk);
		chk("irq cleared", 32'h0, {31'h0, irq});
		wr(pdt_pkg::ADDR_CTRL, 8'hb8);
		repeat (3) @(posedge pclk);
		chk("timer_irq disabled", 32'h0, {31'h0, timer_irq});
		rd_chk(pdt_pkg::ADDR_CTRL, 32'hb8, "flag sticky");
		wr(pdt_pkg::ADDR_CTRL, 8'h00);
		repeat (3) @(posedge pclk);
		chk("timer_pin_oe off", 32'h0, {31'h0, timer_pin_oe});
		rd_chk(pdt_pkg::ADDR_CTRL, 32'h00, "flag cleared");
		wr(pdt_pkg::ADDR_CTRL, 8'ha0);
		repeat (3) @(posedge pclk);
		chk("timer_pin_o low", 32'h0, {31'h0, timer_pin_o});
	endtask

	// main sequence: reset for five cycles, then each scenario in turn
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = 32'h00000000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		t_reset_values();
		t_prescaler_access();
		t_event_count();
		t_write_wins();
		t_gated_count();
		t_divide();
		t_underflow_irq();
		end_of_test();
	end
endmodule

`default_nettype wire
